// File: rtl/pem_pkg.sv
// package for the port e alternate-function multiplexer
// assumes an 8-bit register port with a 3-bit address
package pem_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register addresses
  localparam logic [2:0] OFS_FUNC_SEL  = 3'h0;
  localparam logic [2:0] OFS_GPIO_OUT  = 3'h1;
  localparam logic [2:0] OFS_GPIO_DIR  = 3'h2;
  localparam logic [2:0] OFS_GPIO_IN   = 3'h3;
  localparam logic [2:0] OFS_IFACE_CFG = 3'h4;
  localparam logic [2:0] OFS_FIFO_POL  = 3'h5;
  localparam logic [2:0] OFS_T2_CTRL   = 3'h6;
  localparam logic [2:0] OFS_READY_IN  = 3'h7;

  // reset values
  localparam logic [7:0] RST_FUNC_SEL  = 8'h00;
  localparam logic [7:0] RST_GPIO_OUT  = 8'h00;
  localparam logic [7:0] RST_GPIO_DIR  = 8'h00;
  localparam logic [1:0] RST_IFACE_CFG = 2'h0;
  localparam logic [1:0] RST_FIFO_POL  = 2'h0;
  localparam logic       RST_T2_EN     = 1'b0;

  // implemented port e pins and their alternate functions
  localparam logic [7:0] FUNC_MASK   = 8'hfe;
  localparam int unsigned BIT_T1OVF  = 1;
  localparam int unsigned BIT_T2OVF  = 2;
  localparam int unsigned BIT_S0ECHO = 3;
  localparam int unsigned BIT_S1ECHO = 4;
  localparam int unsigned BIT_INTERRUPT_SIX_INPUT   = 5;
  localparam int unsigned BIT_T2RLD  = 6;
  localparam int unsigned BIT_WADR8  = 7;
  // alternate functions that drive the pin
  localparam logic [7:0] ALT_DRIVES  = 8'h9e;

  // interface configuration mode field, bits 1:0
  localparam logic [1:0] MODE_SLAVE_FIFO = 2'h3;

  // fifo pin polarity bits, 1 = active high
  localparam int unsigned POL_RD_BIT = 3;
  localparam int unsigned POL_WR_BIT = 2;

  // timer-two control reload enable bit
  localparam int unsigned T2_EN_BIT = 3;

  // serial synchronous mode
  localparam logic [1:0] SER_MODE_SYNC = 2'h0;

endpackage

// File: rtl/pem_mux.sv
// port e alternate-function pin multiplexer and ready/strobe input routing
// assumes timer and serial status come from logic on clk; pins are asynchronous
// Function
// R1 - Port e bits 1 to 7 each carry gpio or their alternate function, chosen by the matching select bit.
// R2 - The timer-one overflow output is high for exactly one output-clock cycle per overflow.
// R3 - In timer-one split mode the overflow pulse comes from the low-byte counter.
// R4 - The timer-two overflow output is high for one clock cycle per overflow.
// R5 - The serial-zero echo pin carries output data only in synchronous mode zero, else one.
// R6 - The serial-one echo pin carries output data only in mode zero and is high in modes one to three.
// R7 - The interrupt-six input requests on a rising edge, active high.
// R8 - The timer-two reload input reloads timer two on a falling edge.
// R9 - The reload input is ignored unless the timer-two reload enable bit is set.
// R10 - Port e bit 7 alternate function outputs waveform address bit 8.
// R11 - The interface mode field routes ready zero and one to the waveform engine or the fifo strobes.
// R12 - The fifo read strobe takes the polarity selected by polarity bit 3.
// R13 - The fifo write strobe takes the polarity selected by polarity bit 2.
// R14 - Ready inputs two to five may change at any time and are passed to the waveform engine.
// R15 - After reset every port e pin is a gpio input.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pem_mux
  import pem_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              timer_one_overflow,
  input  wire logic              timer_one_low_overflow,
  input  wire logic              timer_one_split_mode,
  input  wire logic              timer_two_overflow,
  input  wire logic [1:0]        serial_zero_mode,
  input  wire logic              serial_zero_out_data,
  input  wire logic [1:0]        serial_one_mode,
  input  wire logic              serial_one_out_data,
  input  wire logic              waveform_address_bit8,
  input  wire logic [7:1]        porte_pin_in,
  output logic      [7:1]        porte_pin_out,
  output logic      [7:1]        porte_pin_oe,
  input  wire logic [5:0]        ready_pin_in,
  output logic      [5:0]        waveform_ready,
  output logic                   fifo_read_strobe,
  output logic                   fifo_write_strobe,
  output logic                   interrupt_six_request,
  output logic                   timer_two_reload
);

  logic [7:0] porte_function_select_r;
  logic [7:0] gpio_out_r;
  logic [7:0] gpio_dir_r;
  logic [1:0] interface_config_r;
  logic [1:0] fifo_pin_polarity_r;
  logic       timer_two_reload_enable_r;

  logic [7:1] pe_meta_r;
  logic [7:1] pe_sync_r;
  logic [7:1] pe_prev_r;
  logic [5:0] rdy_meta_r;
  logic [5:0] rdy_sync_r;

  logic [7:0] rdata_nxt;
  logic [7:1] alt_out;
  logic       t1_event;
  logic       slave_fifo;

  // register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      porte_function_select_r   <= RST_FUNC_SEL; // [R15]
      gpio_out_r                <= RST_GPIO_OUT;
      gpio_dir_r                <= RST_GPIO_DIR; // [R15]
      interface_config_r        <= RST_IFACE_CFG;
      fifo_pin_polarity_r       <= RST_FIFO_POL;
      timer_two_reload_enable_r <= RST_T2_EN;
    end else if (reg_write) begin
      case (reg_addr)
        OFS_FUNC_SEL:  porte_function_select_r <= reg_wdata & FUNC_MASK; // [R1]
        OFS_GPIO_OUT:  gpio_out_r <= reg_wdata & FUNC_MASK;
        OFS_GPIO_DIR:  gpio_dir_r <= reg_wdata & FUNC_MASK;
        OFS_IFACE_CFG: interface_config_r <= reg_wdata[1:0];
        OFS_FIFO_POL: begin
          fifo_pin_polarity_r <= {reg_wdata[POL_RD_BIT], reg_wdata[POL_WR_BIT]};
        end
        OFS_T2_CTRL:   timer_two_reload_enable_r <= reg_wdata[T2_EN_BIT];
        default: ;
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      OFS_FUNC_SEL:  rdata_nxt = porte_function_select_r;
      OFS_GPIO_OUT:  rdata_nxt = gpio_out_r;
      OFS_GPIO_DIR:  rdata_nxt = gpio_dir_r;
      OFS_GPIO_IN:   rdata_nxt = {pe_sync_r, 1'b0};
      OFS_IFACE_CFG: rdata_nxt = {6'h00, interface_config_r};
      OFS_FIFO_POL: begin
        rdata_nxt[POL_RD_BIT] = fifo_pin_polarity_r[1];
        rdata_nxt[POL_WR_BIT] = fifo_pin_polarity_r[0];
      end
      OFS_T2_CTRL:   rdata_nxt[T2_EN_BIT] = timer_two_reload_enable_r;
      OFS_READY_IN:  rdata_nxt = {2'h0, rdy_sync_r};
      default:       rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // port e synchronisers keep tracking through reset, so no false edge follows it
  always_ff @(posedge clk) begin
    pe_meta_r <= porte_pin_in;
    pe_sync_r <= pe_meta_r;
    pe_prev_r <= pe_sync_r;
  end

  // two-stage synchronisers for ready inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      rdy_meta_r <= 6'h00;
      rdy_sync_r <= 6'h00;
    end else begin
      rdy_meta_r <= ready_pin_in;
      rdy_sync_r <= rdy_meta_r;
    end
  end

  // alternate output functions
  assign t1_event = timer_one_split_mode ? timer_one_low_overflow // [R3]
                                         : timer_one_overflow;     // [R2]

  always_comb begin
    alt_out = 7'h00;
    alt_out[BIT_T1OVF] = t1_event; // [R2]
    alt_out[BIT_T2OVF] = timer_two_overflow; // [R4]
    alt_out[BIT_S0ECHO] = (serial_zero_mode == SER_MODE_SYNC) ? serial_zero_out_data // [R5]
                                                              : 1'b1;
    alt_out[BIT_S1ECHO] = (serial_one_mode == SER_MODE_SYNC) ? serial_one_out_data // [R6]
                                                             : 1'b1;
    alt_out[BIT_WADR8] = waveform_address_bit8; // [R10]
  end

  // pin drive: gpio or alternate function per select bit
  always_ff @(posedge clk) begin
    if (reset) begin
      porte_pin_out <= 7'h00;
      porte_pin_oe  <= 7'h00; // [R15]
    end else begin
      for (int i = 1; i < 8; i++) begin
        if (porte_function_select_r[i]) begin // [R1]
          porte_pin_out[i] <= alt_out[i];
          porte_pin_oe[i]  <= ALT_DRIVES[i];
        end else begin
          porte_pin_out[i] <= gpio_out_r[i];
          porte_pin_oe[i]  <= gpio_dir_r[i];
        end
      end
    end
  end

  // alternate input functions
  always_ff @(posedge clk) begin
    if (reset) begin
      interrupt_six_request <= 1'b0;
      timer_two_reload      <= 1'b0;
    end else begin
      interrupt_six_request <= porte_function_select_r[BIT_INTERRUPT_SIX_INPUT] // [R7]
                               & pe_sync_r[BIT_INTERRUPT_SIX_INPUT] & ~pe_prev_r[BIT_INTERRUPT_SIX_INPUT];
      timer_two_reload      <= porte_function_select_r[BIT_T2RLD] // [R8]
                               & timer_two_reload_enable_r         // [R9]
                               & ~pe_sync_r[BIT_T2RLD] & pe_prev_r[BIT_T2RLD];
    end
  end

  // ready inputs: waveform engine or slave fifo strobes
  assign slave_fifo = (interface_config_r == MODE_SLAVE_FIFO); // [R11]

  always_ff @(posedge clk) begin
    if (reset) begin
      waveform_ready    <= 6'h00;
      fifo_read_strobe  <= 1'b0;
      fifo_write_strobe <= 1'b0;
    end else begin
      waveform_ready[5:2] <= rdy_sync_r[5:2]; // [R14]
      waveform_ready[1:0] <= slave_fifo ? 2'h0 : rdy_sync_r[1:0]; // [R11]
      fifo_read_strobe    <= slave_fifo // [R12]
                             & ~(rdy_sync_r[0] ^ fifo_pin_polarity_r[1]);
      fifo_write_strobe   <= slave_fifo // [R13]
                             & ~(rdy_sync_r[1] ^ fifo_pin_polarity_r[0]);
    end
  end

endmodule
`default_nettype wire

// File: tb/pem_chk.sv
// port assertions for the pin multiplexer, with a shadow of the select register
// assumes it is bound into pem_mux and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module pem_chk
  import pem_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              timer_one_overflow,
  input wire logic              timer_one_low_overflow,
  input wire logic              timer_one_split_mode,
  input wire logic              timer_two_overflow,
  input wire logic [1:0]        serial_zero_mode,
  input wire logic              serial_zero_out_data,
  input wire logic [1:0]        serial_one_mode,
  input wire logic              serial_one_out_data,
  input wire logic              waveform_address_bit8,
  input wire logic [7:1]        porte_pin_in,
  input wire logic [7:1]        porte_pin_out,
  input wire logic [7:1]        porte_pin_oe,
  input wire logic              interrupt_six_request,
  input wire logic              timer_two_reload
);
  logic [7:0] sel_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_r <= 8'h00;
    end else if (reg_write && reg_addr == OFS_FUNC_SEL) begin
      sel_r <= reg_wdata & FUNC_MASK;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property (disable iff (1'b0) reset |=>
    porte_pin_oe == 7'h00 && !interrupt_six_request && !timer_two_reload)
    else $error("outputs active after reset");
  a_t1_pulse: assert property (sel_r[1] |=> porte_pin_oe[1] && porte_pin_out[1] ==
    $past(timer_one_split_mode ? timer_one_low_overflow : timer_one_overflow))
    else $error("timer one pulse wrong");
  a_t2_pulse: assert property (sel_r[2] |=>
    porte_pin_oe[2] && porte_pin_out[2] == $past(timer_two_overflow))
    else $error("timer two pulse wrong");
  a_s0_echo: assert property (sel_r[3] |=> porte_pin_oe[3] && porte_pin_out[3] ==
    $past(serial_zero_mode != SER_MODE_SYNC || serial_zero_out_data))
    else $error("serial zero echo wrong");
  a_s1_echo: assert property (sel_r[4] |=> porte_pin_oe[4] && porte_pin_out[4] ==
    $past(serial_one_mode != SER_MODE_SYNC || serial_one_out_data))
    else $error("serial one echo wrong");
  a_addr8_out: assert property (sel_r[7] |=>
    porte_pin_oe[7] && porte_pin_out[7] == $past(waveform_address_bit8))
    else $error("address bit wrong");
  a_interrupt_six_input_edge: assert property (interrupt_six_request |->
    $past(porte_pin_in[5], 3) && !$past(porte_pin_in[5], 4)) else $error("request without rise");
  a_reload_edge: assert property (timer_two_reload |->
    !$past(porte_pin_in[6], 3) && $past(porte_pin_in[6], 4)) else $error("reload without fall");
  c_split: cover property (sel_r[1] && timer_one_split_mode && timer_one_low_overflow);
  c_interrupt_six_input: cover property (interrupt_six_request);
  c_reload: cover property (timer_two_reload);
endmodule
bind pem_mux pem_chk u_chk (.*);
`default_nettype wire

// File: tb/pem_peer.sv
// stand-in for the timers, serial units and outside pin drivers
// assumes the bench owns clk and reset; pin and ready levels are held four cycles
`timescale 1ns/1ps
`default_nettype none
module pem_peer (
  input  wire logic       clk,
  input  wire logic       reset,
  output logic            t1_ovf = 1'b0,
  output logic            t1_low = 1'b0,
  output logic            t2_ovf = 1'b0,
  output logic [1:0]      sdat = 2'h0,
  output logic            wadr8 = 1'b0,
  output logic [7:1]      ext_pin = 7'h00,
  output logic [5:0]      rdy_pin = 6'h00
);
  logic [4:0] cnt_r = 5'h00;
  always @(posedge clk) begin
    cnt_r  <= reset ? 5'h00 : cnt_r + 5'h01;
    t1_ovf <= cnt_r[2:0] == 3'h7;
    t1_low <= cnt_r[1:0] == 2'h1;
    t2_ovf <= cnt_r[3:0] == 4'h3;
    sdat   <= 2'($urandom);
    wadr8  <= cnt_r[4];
    if (cnt_r[1:0] == 2'h0) begin
      ext_pin <= 7'($urandom);
      rdy_pin <= 6'($urandom);
    end
  end
endmodule
`default_nettype wire

// File: tb/pem_mux_bench.sv
// self-checking bench: cycle model of registers, pin mux and input edges
// assumes pem_peer drives the far side; released pins show the outside level
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t mismatch", $time); end end
module pem_mux_bench
  import pem_pkg::*;
;
  localparam logic [7:0] MSK [8] = '{8'hfe, 8'hfe, 8'hfe, 8'h00, 8'h03, 8'h0c, 8'h08, 8'h00};
  logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, split = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, m [8], eo, eoe, alt;
  logic [1:0] smd0 = 2'h0, smd1 = 2'h0;
  logic [12:0] h1, h2, h3;
  logic [5:0] erdy;
  logic ei6, erl, erd, ewr;
  int n_fail = 0, cmp_count = 0, qt = 0, cyc = 0;
  wire logic [7:0] reg_rdata;
  wire logic t1, t1l, t2, wa8, frd, fwr, i6, t2r;
  wire logic [1:0] sd;
  wire logic [7:1] ext, pout, poe, pin;
  wire logic [5:0] rdy, wrdy;
  assign pin = (poe & pout) | (~poe & ext);
  pem_peer peer_u (.clk(clk), .reset(reset), .t1_ovf(t1), .t1_low(t1l), .t2_ovf(t2),
    .sdat(sd), .wadr8(wa8), .ext_pin(ext), .rdy_pin(rdy));
  pem_mux dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_one_overflow(t1), .timer_one_low_overflow(t1l), .timer_one_split_mode(split),
    .timer_two_overflow(t2), .serial_zero_mode(smd0), .serial_zero_out_data(sd[0]),
    .serial_one_mode(smd1), .serial_one_out_data(sd[1]), .waveform_address_bit8(wa8),
    .porte_pin_in(pin), .porte_pin_out(pout), .porte_pin_oe(poe), .ready_pin_in(rdy),
    .waveform_ready(wrdy), .fifo_read_strobe(frd), .fifo_write_strobe(fwr),
    .interrupt_six_request(i6), .timer_two_reload(t2r));
  initial forever #25 clk = ~clk;
  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    #1 if (MSK[a] != 8'h00) `CK(reg_rdata, m[a])
  endtask
  always @(posedge clk) begin
    cyc++;
    alt = {wa8, 2'b00, smd1 != 2'h0 || sd[1], smd0 != 2'h0 || sd[0], t2, split ? t1l : t1, 1'b0};
    eo = (m[0] & alt) | (~m[0] & m[1]);
    eoe = (m[0] & ALT_DRIVES) | (~m[0] & m[2]);
    ei6 = h2[4] & ~h3[4] & m[0][5];
    erl = ~h2[5] & h3[5] & m[0][6] & m[6][T2_EN_BIT];
    erd = h2[7] ~^ m[5][POL_RD_BIT];
    ewr = h2[8] ~^ m[5][POL_WR_BIT];
    erdy = h2[12:7] & (m[4][1:0] == MODE_SLAVE_FIFO ? 6'h3c : 6'h3f);
    {h3, h2, h1} = {h2, h1, rdy, pin};
    qt++;
    if (reg_write) begin
      m[reg_addr] = reg_wdata & MSK[reg_addr];
      qt = 0;
    end
    if (reset) begin
      foreach (m[i]) m[i] = 8'h00;
      {eo, eoe, qt} = '0;
    end
    if (cyc > 6000) begin
      n_fail++;
      report_and_stop();
    end
  end
  always @(negedge clk) if (cyc > 0) begin
    `CK(poe, eoe[7:1])
    `CK(pout & poe, eo[7:1] & eoe[7:1])
    if (qt > 4) begin
      `CK(i6, ei6)
      `CK(t2r, erl)
      `CK(wrdy, erdy)
      if (m[4][1:0] == MODE_SLAVE_FIFO) `CK({frd, fwr}, {erd, ewr})
      else `CK({frd, fwr}, 2'b00)
    end
  end
  initial begin
    void'($urandom(32'hb927));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a));
    for (int a = 0; a < 8; a++) bus(1'b1, 1'b0, 3'(a), 8'($urandom));
    for (int a = 0; a < 8; a++) rd(3'(a));
    for (int i = 0; i < 8; i++) begin
      split <= i[2];
      smd0 <= 2'(i);
      smd1 <= 2'(3 - i);
      for (int a = 0; a < 7; a++)
        bus(1'b1, 1'b0, 3'(a), (a == 0 && i[0]) ? 8'hfe : a == 4 ? 8'(i) : 8'($urandom));
      repeat (60) bus(1'b0, 1'b0, 3'h0, 8'h00);
    end
    reset <= 1'b1;
    repeat (2) bus(1'b0, 1'b0, 3'h0, 8'h00);
    reset <= 1'b0;
    rd(OFS_FUNC_SEL);
    report_and_stop();
  end
endmodule
`default_nettype wire
